// ==== rtl/acs_sequencer.sv ====
// Conversion sequencer: power-on reset, conversion timing, clock source choice and target address answer.
// What this block does
// - After a finished conversion an acknowledged write then STOP restarts conversion, discarding the result.
// - A configuration byte received in that write is stored and used by the next conversion.
// - Acknowledge writes to global address 1110111 as well as the own address.
// - STOP after a global write loads any received byte and starts conversion.
// - STOP right after the global address starts conversion, configuration unchanged.
// - Rejection mode comes from configuration; power-up default is simultaneous 50/60 Hz.
// - Detect a clock on the shared pin and then use it as conversion clock.
// - Only toggling at 10 kHz or faster counts as an external clock.
// - With an external clock present the pin's address bit reads as high.
// - With external clock the filter notch sits at clock frequency divided by 5120.
// - Without external clock fall back to the internal oscillator automatically.
// - Source change only spoils the conversion in progress, never later ones.
// - Internal clock, 60 Hz: 133 ms normal, 67 ms double speed.
// - Internal clock, 50 Hz: 160 ms normal, 80 ms double speed.
// - Internal clock, 50/60 Hz: 147 ms normal, 73.6 ms double speed.
// - External clock: 41036 periods normal, 20556 periods double speed.
// - Offset and full-scale calibration inside every conversion, invisible outside.
// - Each conversion yields exactly one valid word, no pipeline latency.
// - Hold an internal reset of about 4 ms at power-up.
// - Reset loads a default value into every register, then a conversion starts without any command.
// - Default configuration: external input, gain one, 50/60 Hz, normal speed.
// - Answer own address with not-acknowledge while converting.
// - Data phase ends and conversion starts on STOP or after 24 bits read.
module acs_sequencer #(
  parameter int unsigned POR_CYCLES     = acs_pkg::POR_CYC,
  parameter int unsigned CONV_60_1X     = acs_pkg::CONV_60_1X_CYC,
  parameter int unsigned CONV_60_2X     = acs_pkg::CONV_60_2X_CYC,
  parameter int unsigned CONV_50_1X     = acs_pkg::CONV_50_1X_CYC,
  parameter int unsigned CONV_50_2X     = acs_pkg::CONV_50_2X_CYC,
  parameter int unsigned CONV_5060_1X   = acs_pkg::CONV_5060_1X_CYC,
  parameter int unsigned CONV_5060_2X   = acs_pkg::CONV_5060_2X_CYC,
  parameter int unsigned EXT_1X_PERIODS = acs_pkg::EXT_CONV_1X_PER,
  parameter int unsigned EXT_2X_PERIODS = acs_pkg::EXT_CONV_2X_PER
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_addr_or_ext_clock_pin,
  input  wire logic [5:0] i_own_addr_upper,
  input  wire logic       i_addr_valid,
  input  wire logic [6:0] i_addr,
  input  wire logic       i_addr_rd,
  input  wire logic       i_cfg_byte_valid,
  input  wire logic [7:0] i_cfg_byte,
  input  wire logic       i_stop,
  input  wire logic       i_read_done,
  output logic            o_addr_ack,
  output logic            o_por_active,
  output logic            o_converting,
  output logic            o_cal_active,
  output logic            o_data_ready,
  output logic            o_result_strobe,
  output logic            o_result_suspect,
  output logic            o_ext_clk_present,
  output logic            o_addr_lsb,
  output logic [7:0]      o_cfg
);

  // Every terminal count must be at least two so the counter has a real span.
  // The check runs at elaboration, so a bad count never reaches a build.
  if (POR_CYCLES < 2 || CONV_60_1X < 2 || CONV_60_2X < 2 || CONV_50_1X < 2 || CONV_50_2X < 2 ||
      CONV_5060_1X < 2 || CONV_5060_2X < 2 || EXT_1X_PERIODS < 2 || EXT_2X_PERIODS < 2) begin : g_bad_counts
    $error("acs_sequencer: terminal counts must be at least 2");
  end

  acs_pkg::acs_state_t            state_q;
  logic [acs_pkg::CNT_W-1:0]      por_cnt_q;
  logic [acs_pkg::CNT_W-1:0]      conv_cnt_q;
  logic [acs_pkg::CNT_W-1:0]      term_cnt;
  logic [acs_pkg::GAP_W-1:0]      gap_q;
  logic                           pin_q;
  logic                           ext_rise;
  logic                           ext_q;
  logic                           conv_tick;
  logic                           conv_done;
  logic                           start_conv;
  logic                           por_done;
  logic [7:0]                     cfg_q;
  logic [7:0]                     pend_q;
  logic                           pend_valid_q;
  logic                           ready_q;
  logic                           strobe_q;
  logic                           suspect_q;
  logic                           ext_at_start_q;
  logic                           own_match;
  logic                           glob_match;
  logic [1:0]                     rej;
  logic                           dbl_speed;

  // The pin is taken as synchronous, so one flop is enough to find its rising edges.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= i_addr_or_ext_clock_pin;
    end
  end

  assign ext_rise = i_addr_or_ext_clock_pin & ~pin_q;

  // Cycles since the last rising edge, saturating at the timeout.
  // Reset starts the count saturated: the edge flop wakes up low, so a pin tied high
  // would otherwise show a false edge after reset and fake a present clock.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_q <= acs_pkg::GAP_W'(acs_pkg::EXT_TIMEOUT_CYC);
    end else if (ext_rise) begin
      gap_q <= '0;
    end else if (gap_q < acs_pkg::GAP_W'(acs_pkg::EXT_TIMEOUT_CYC)) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // A clock counts as present only while edges come closer than the slowest allowed period.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_q <= 1'b0;
    end else if (gap_q >= acs_pkg::GAP_W'(acs_pkg::EXT_TIMEOUT_CYC)) begin
      ext_q <= 1'b0;
    end else if (ext_rise) begin
      ext_q <= 1'b1;
    end
  end

  // A static pin level sets the address bit; a running clock forces it high.
  assign o_addr_lsb = ext_q ? 1'b1 : pin_q;

  // Address decode; the global address is a write-only selection.
  // A global read is refused, since every device would then drive the data line at once.
  assign own_match  = (i_addr == {i_own_addr_upper, o_addr_lsb});
  assign glob_match = (i_addr == acs_pkg::GLOBAL_ADDR) && !i_addr_rd;

  // Only an idle or already selected device answers; a busy one stays silent.
  assign o_addr_ack = i_addr_valid && (own_match || glob_match) &&
                      (state_q == acs_pkg::ST_SLEEP || (state_q == acs_pkg::ST_IO && !i_read_done));

  // Power-on reset timer, held at its end once expired.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_cnt_q <= '0;
    end else if (state_q == acs_pkg::ST_POR && !por_done) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  assign por_done = (por_cnt_q == acs_pkg::CNT_W'(POR_CYCLES - 1));

  // Fields steering the conversion length.
  assign rej       = cfg_q[acs_pkg::CFG_REJ_LSB +: acs_pkg::CFG_REJ_W];
  assign dbl_speed = cfg_q[acs_pkg::CFG_SPEED_BIT];

  // Terminal count follows the live clock source; an external clock counts its periods.
  // The notch then lands at the clock rate over 5120 because the period counts are fixed.
  always_comb begin
    term_cnt = acs_pkg::CNT_W'(CONV_5060_1X);
    if (ext_q) begin
      term_cnt = dbl_speed ? acs_pkg::CNT_W'(EXT_2X_PERIODS) : acs_pkg::CNT_W'(EXT_1X_PERIODS);
    end else begin
      case (rej)
        acs_pkg::REJ_60: term_cnt = dbl_speed ? acs_pkg::CNT_W'(CONV_60_2X) : acs_pkg::CNT_W'(CONV_60_1X);
        acs_pkg::REJ_50: term_cnt = dbl_speed ? acs_pkg::CNT_W'(CONV_50_2X) : acs_pkg::CNT_W'(CONV_50_1X);
        default: term_cnt = dbl_speed ? acs_pkg::CNT_W'(CONV_5060_2X) : acs_pkg::CNT_W'(CONV_5060_1X);
      endcase
    end
  end

  // The internal oscillator is modelled by the system clock itself.
  assign conv_tick = ext_q ? ext_rise : 1'b1;
  assign conv_done = (state_q == acs_pkg::ST_CONV) && conv_tick && (conv_cnt_q >= term_cnt - 1'b1);

  // Conversions start after reset, after a STOP in the data phase, or after 24 bits are read.
  assign start_conv = (state_q == acs_pkg::ST_POR && por_done) ||
                      (state_q == acs_pkg::ST_IO && (i_stop || i_read_done));

  // Duration counter on the selected clock.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_cnt_q <= '0;
    end else if (start_conv) begin
      conv_cnt_q <= '0;
    end else if (state_q == acs_pkg::ST_CONV && conv_tick) begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // Main sequence: power-on reset, conversion, sleep, data phase.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= acs_pkg::ST_POR;
    end else begin
      case (state_q)
        acs_pkg::ST_POR: begin
          if (por_done) begin
            state_q <= acs_pkg::ST_CONV;
          end
        end
        acs_pkg::ST_CONV: begin
          if (conv_done) begin
            state_q <= acs_pkg::ST_SLEEP;
          end
        end
        acs_pkg::ST_SLEEP: begin
          if (o_addr_ack) begin
            state_q <= acs_pkg::ST_IO;
          end
        end
        acs_pkg::ST_IO: begin
          if (i_stop || i_read_done) begin
            state_q <= acs_pkg::ST_CONV;
          end
        end
        default: state_q <= acs_pkg::ST_POR;
      endcase
    end
  end

  // A byte is pending only once fully received and acknowledged; a bare STOP loads nothing.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_q       <= acs_pkg::CFG_RESET;
      pend_valid_q <= 1'b0;
    end else if (start_conv) begin
      pend_valid_q <= 1'b0;
    end else if (state_q == acs_pkg::ST_IO && i_cfg_byte_valid) begin
      pend_q       <= i_cfg_byte;
      pend_valid_q <= 1'b1;
    end
  end

  // Configuration changes only at a conversion start, so a running conversion keeps its mode.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_q <= acs_pkg::CFG_RESET;
    end else if (start_conv && pend_valid_q) begin
      cfg_q <= pend_q;
    end
  end

  // One result per conversion; a restart throws the unread word away.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_q  <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= conv_done;
      if (conv_done) begin
        ready_q <= 1'b1;
      end else if (start_conv) begin
        ready_q <= 1'b0;
      end
    end
  end

  // Note the source in use at start; a change mid-conversion marks only that result.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_at_start_q <= 1'b0;
      suspect_q      <= 1'b0;
    end else if (start_conv) begin
      ext_at_start_q <= ext_q;
      suspect_q      <= 1'b0;
    end else if (state_q == acs_pkg::ST_CONV && ext_q != ext_at_start_q) begin
      suspect_q <= 1'b1;
    end
  end

  // Calibration occupies the first eighth of each conversion, hidden inside its length.
  assign o_cal_active = (state_q == acs_pkg::ST_CONV) &&
                        (conv_cnt_q < (term_cnt >> acs_pkg::CAL_SHIFT));

  assign o_por_active      = (state_q == acs_pkg::ST_POR);
  assign o_converting      = (state_q == acs_pkg::ST_CONV);
  assign o_data_ready      = ready_q;
  assign o_result_strobe   = strobe_q;
  assign o_result_suspect  = suspect_q;
  assign o_ext_clk_present = ext_q;
  assign o_cfg             = cfg_q;

  // Checks on the sequence.
  a_nak_while_busy: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_CONV) |-> !o_addr_ack)
    else $error("address acknowledged during conversion");

  a_global_ack: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_SLEEP && i_addr_valid && i_addr == acs_pkg::GLOBAL_ADDR && !i_addr_rd) |-> o_addr_ack)
    else $error("global write not acknowledged");

  a_stop_restarts: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_stop) |=> (state_q == acs_pkg::ST_CONV && !o_data_ready && conv_cnt_q == '0))
    else $error("stop did not restart conversion");

  a_cfg_loaded: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_stop && pend_valid_q) |=> (cfg_q == $past(pend_q)))
    else $error("received configuration not applied");

  a_cfg_kept: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_stop && !pend_valid_q && !i_cfg_byte_valid) |=> $stable(cfg_q))
    else $error("configuration changed without a byte");

  a_ext_addr_high: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    ext_q |-> o_addr_lsb)
    else $error("address bit low with external clock");

  a_slow_clk_lost: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (gap_q >= acs_pkg::GAP_W'(acs_pkg::EXT_TIMEOUT_CYC)) |=> !ext_q)
    else $error("slow clock still treated as present");

  a_one_result: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    conv_done |=> (o_result_strobe && o_data_ready && state_q == acs_pkg::ST_SLEEP) ##1 !o_result_strobe)
    else $error("conversion end did not give one result");

  a_read_done_restarts: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_read_done) |=> (state_q == acs_pkg::ST_CONV))
    else $error("full read did not start conversion");

  a_por_to_conv: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_POR && por_done) |=> (state_q == acs_pkg::ST_CONV && cfg_q == acs_pkg::CFG_RESET))
    else $error("power-on reset did not start a default conversion");

  a_int_tick: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_CONV && !ext_q && !conv_done) |=> (conv_cnt_q == $past(conv_cnt_q) + 1'b1))
    else $error("internal clock not counting");

  c_global_sync: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_SLEEP && o_addr_ack && i_addr == acs_pkg::GLOBAL_ADDR) ##[1:20] (i_stop && state_q == acs_pkg::ST_IO));

  c_cfg_update: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_stop && pend_valid_q));

  c_ext_clock: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (ext_q && conv_done));

  c_full_read: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (state_q == acs_pkg::ST_IO && i_read_done));

endmodule : acs_sequencer

// ==== rtl/acs_pkg.sv ====
// Constants, encodings and timing figures shared by the conversion sequencer.
package acs_pkg;

  // System clock rate and derived cycles per microsecond.
  localparam int unsigned SYS_CLK_HZ       = 25_000_000;
  localparam int unsigned SYS_CYC_PER_US   = SYS_CLK_HZ / 1_000_000;

  // Bus address figures.
  localparam int unsigned ADDR_W           = 7;
  localparam logic [6:0]  GLOBAL_ADDR      = 7'h77;
  localparam int unsigned ADDR_PIN_BIT_POS = 0;

  // Configuration byte layout and reset value.
  localparam int unsigned CFG_W            = 8;
  localparam int unsigned CFG_REJ_LSB      = 0;
  localparam int unsigned CFG_REJ_W        = 2;
  localparam int unsigned CFG_SPEED_BIT    = 2;
  localparam int unsigned CFG_GAIN_LSB     = 3;
  localparam int unsigned CFG_GAIN_W       = 3;
  localparam int unsigned CFG_TEMP_BIT     = 6;
  localparam logic [7:0]  CFG_RESET        = 8'h00;

  // Line rejection mode encodings.
  localparam logic [1:0]  REJ_50_60        = 2'h0;
  localparam logic [1:0]  REJ_50           = 2'h1;
  localparam logic [1:0]  REJ_60           = 2'h2;

  // Power-on reset duration.
  localparam int unsigned T_POR_US         = 4_000;
  localparam int unsigned POR_CYC          = T_POR_US * SYS_CYC_PER_US;

  // Internal oscillator conversion times, in microseconds.
  localparam int unsigned T_CONV_60_1X_US  = 133_000;
  localparam int unsigned T_CONV_60_2X_US  = 67_000;
  localparam int unsigned T_CONV_50_1X_US  = 160_000;
  localparam int unsigned T_CONV_50_2X_US  = 80_000;
  localparam int unsigned T_CONV_5060_1X_US = 147_000;
  localparam int unsigned T_CONV_5060_2X_US = 73_600;
  localparam int unsigned CONV_60_1X_CYC   = T_CONV_60_1X_US * SYS_CYC_PER_US;
  localparam int unsigned CONV_60_2X_CYC   = T_CONV_60_2X_US * SYS_CYC_PER_US;
  localparam int unsigned CONV_50_1X_CYC   = T_CONV_50_1X_US * SYS_CYC_PER_US;
  localparam int unsigned CONV_50_2X_CYC   = T_CONV_50_2X_US * SYS_CYC_PER_US;
  localparam int unsigned CONV_5060_1X_CYC = T_CONV_5060_1X_US * SYS_CYC_PER_US;
  localparam int unsigned CONV_5060_2X_CYC = T_CONV_5060_2X_US * SYS_CYC_PER_US;

  // External conversion clock periods per conversion and filter notch divisor.
  localparam int unsigned EXT_CONV_1X_PER  = 41_036;
  localparam int unsigned EXT_CONV_2X_PER  = 20_556;
  localparam int unsigned EXT_NOTCH_DIV    = 5_120;

  // Slowest recognised external clock: one period of the 10 kHz minimum.
  localparam int unsigned T_EXT_MAX_PER_US = 100;
  localparam int unsigned EXT_TIMEOUT_CYC  = T_EXT_MAX_PER_US * SYS_CYC_PER_US;
  localparam int unsigned GAP_W            = 12;

  // Conversion counter width and calibration share (one eighth of the cycle).
  localparam int unsigned CNT_W            = 32;
  localparam int unsigned CAL_SHIFT        = 3;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_POR   = 4'h1,
    ST_CONV  = 4'h2,
    ST_SLEEP = 4'h4,
    ST_IO    = 4'h8
  } acs_state_t;

endpackage : acs_pkg

// ==== verification/acs_host_model.sv ====
// I2C controller model that turns bus transactions into the sequencer's front-end event pulses.
module acs_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_addr_ack,
  output logic            o_addr_valid,
  output logic [6:0]      o_addr,
  output logic            o_addr_rd,
  output logic            o_cfg_byte_valid,
  output logic [7:0]      o_cfg_byte,
  output logic            o_stop,
  output logic            o_read_done
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus starts idle with no event pending.
  initial begin
    o_addr_valid = 1'b0;
    o_addr = 7'h00;
    o_addr_rd = 1'b0;
    o_cfg_byte_valid = 1'b0;
    o_cfg_byte = 8'h00;
    o_stop = 1'b0;
    o_read_done = 1'b0;
  end

  // One transaction: address, optional byte, then STOP or the end of a full read.
  // After a NAK only STOP follows, as a real controller would send.
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic with_cfg,
                      input logic [7:0] cfg, input logic by_read, output logic ack);
    @(posedge i_sys_clk);
    o_addr_valid <= 1'b1;
    o_addr <= addr;
    o_addr_rd <= rd;
    @(posedge i_sys_clk);
    ack = i_addr_ack;
    o_addr_valid <= 1'b0;
    o_addr <= ~addr;  // Stale fields are scrambled so nothing leans on them.
    if (ack === 1'b1 && with_cfg === 1'b1) begin
      o_cfg_byte_valid <= 1'b1;
      o_cfg_byte <= cfg;
      @(posedge i_sys_clk);
      o_cfg_byte_valid <= 1'b0;
      o_cfg_byte <= ~cfg;
    end
    if (ack === 1'b1 && by_read === 1'b1) begin
      o_read_done <= 1'b1;
    end else begin
      o_stop <= 1'b1;
    end
    @(posedge i_sys_clk);
    o_stop <= 1'b0;
    o_read_done <= 1'b0;
  endtask : xfer
endmodule : acs_host_model

// ==== verification/acs_sequencer_tb.sv ====
// Self-checking bench for the conversion sequencer against a model of modes and timing.
module acs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened counts; every expectation derives from these.
  localparam int P_POR = 20;
  localparam int T60A = 60;
  localparam int T60B = 30;
  localparam int T50A = 80;
  localparam int T50B = 44;
  localparam int TMXA = 72;
  localparam int TMXB = 36;
  localparam int E1X = 10;
  localparam int E2X = 6;
  logic       i_sys_clk;
  logic       i_arst_n;
  logic       pin;
  logic       pin_static;
  logic [5:0] own_upper;
  logic [7:0] exp_cfg;
  logic       ext_en;
  logic       ext_on;
  logic       ack;
  int         ext_per;
  int         ext_cnt;
  int         seed;
  int         n;
  int         cal_n;
  int         strb_n;
  int         num_errors;
  int         cmp_count;
  wire        a_valid, a_rd, c_valid, stop, rdone;
  wire  [6:0] a_addr;
  wire  [7:0] c_byte;
  wire        o_addr_ack, o_por_active, o_converting, o_cal_active, o_data_ready;
  wire        o_result_strobe, o_result_suspect, o_ext_clk_present, o_addr_lsb;
  wire  [7:0] o_cfg;

  acs_sequencer #(.POR_CYCLES(P_POR), .CONV_60_1X(T60A), .CONV_60_2X(T60B), .CONV_50_1X(T50A),
    .CONV_50_2X(T50B), .CONV_5060_1X(TMXA), .CONV_5060_2X(TMXB), .EXT_1X_PERIODS(E1X),
    .EXT_2X_PERIODS(E2X)) u_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_addr_or_ext_clock_pin(pin), .i_own_addr_upper(own_upper), .i_addr_valid(a_valid),
    .i_addr(a_addr), .i_addr_rd(a_rd), .i_cfg_byte_valid(c_valid), .i_cfg_byte(c_byte),
    .i_stop(stop), .i_read_done(rdone), .o_addr_ack(o_addr_ack), .o_por_active(o_por_active),
    .o_converting(o_converting), .o_cal_active(o_cal_active), .o_data_ready(o_data_ready),
    .o_result_strobe(o_result_strobe), .o_result_suspect(o_result_suspect),
    .o_ext_clk_present(o_ext_clk_present), .o_addr_lsb(o_addr_lsb), .o_cfg(o_cfg));

  acs_host_model u_host (.i_sys_clk(i_sys_clk), .i_addr_ack(o_addr_ack), .o_addr_valid(a_valid),
    .o_addr(a_addr), .o_addr_rd(a_rd), .o_cfg_byte_valid(c_valid), .o_cfg_byte(c_byte),
    .o_stop(stop), .o_read_done(rdone));

  // The 25 MHz system clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Shared pin: static address level, or a toggling conversion clock of ext_per cycles.
  always @(posedge i_sys_clk) begin
    if (ext_en) begin
      ext_cnt <= (ext_cnt + 1) % ext_per;
      pin <= (ext_cnt < ext_per / 2);
    end else begin
      ext_cnt <= 0;
      pin <= pin_static;
    end
  end

  // Counters of result strobes and calibration cycles seen.
  always @(posedge i_sys_clk) begin
    if (i_arst_n !== 1'b1) begin
      strb_n <= 0;
      cal_n <= 0;
    end else begin
      if (o_result_strobe === 1'b1) strb_n <= strb_n + 1;
      if (o_cal_active === 1'b1) cal_n <= cal_n + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Internal conversion length from rejection mode and speed; code 3 acts as 50/60.
  function automatic int exp_term(input logic [7:0] c);
    logic f;
    f = c[acs_pkg::CFG_SPEED_BIT];
    case (c[1:0])
      2'h1: return f ? T50B : T50A;
      2'h2: return f ? T60B : T60A;
      default: return f ? TMXB : TMXA;
    endcase
  endfunction : exp_term

  // Follows one conversion from its start edge to the result; nak probes the busy answer.
  task automatic conv_check(input int lo, input int hi, input logic nak);
    logic k;
    int   c;
    int   s0;
    int   c0;
    c = 0;
    s0 = strb_n;
    c0 = cal_n;
    check("start", 32'(o_converting), 32'h1);
    check("discard", 32'(o_data_ready), 32'h0);
    if (nak) begin
      u_host.xfer({own_upper, pin_static}, 1'b0, 1'b0, 8'h00, 1'b0, k);
      check("busy_ack", 32'(k), 32'h0);
      c = 3;
    end
    while (o_converting === 1'b1 && c < 20000) begin
      @(posedge i_sys_clk);
      #1;
      c++;
    end
    check("conv_len", 32'(c >= lo && c <= hi), 32'h1);
    if (lo == hi) check("cal_len", 32'(cal_n - c0), 32'(lo >> acs_pkg::CAL_SHIFT));
    repeat (3) @(posedge i_sys_clk);
    #1;
    check("one_word", 32'(strb_n - s0), 32'h1);
    check("ready", 32'(o_data_ready), 32'h1);
  endtask : conv_check

  // One transaction and what the model expects of it; reads end after the full word.
  task automatic access(input logic [6:0] a, input logic rd, input logic wc, input logic [7:0] c,
                        input logic exp_ack);
    logic k;
    int   t;
    u_host.xfer(a, rd, wc, c, rd, k);
    check("ack", 32'(k), 32'(exp_ack));
    if (exp_ack && wc) exp_cfg = c;
    #1;
    check("cfg", 32'(o_cfg), 32'(exp_cfg));
    if (!exp_ack) begin
      check("idle", 32'(o_converting), 32'h0);
    end else if (ext_on) begin
      t = (exp_cfg[acs_pkg::CFG_SPEED_BIT] ? E2X : E1X) * ext_per;
      conv_check(t - ext_per, t + 2 * ext_per, 1'b0);
    end else begin
      t = exp_term(exp_cfg);
      conv_check(t, t, 1'b0);
    end
  endtask : access

  // Hang guard sized well beyond the roughly 16000 cycles of the sequence.
  initial begin
    #2400000;
    num_errors++;
    finish_test();
  end

  // Main sequence. Own address stays below 0x40 so a flipped bit never hits the global one.
  initial begin
    seed = 22980;
    num_errors = 0;
    cmp_count = 0;
    i_arst_n = 1'b0;
    ext_en = 1'b0;
    ext_on = 1'b0;
    ext_per = 40;
    pin_static = 1'($random(seed));
    own_upper = 6'($random(seed)) & 6'h1F;
    exp_cfg = acs_pkg::CFG_RESET;
    repeat (6) @(posedge i_sys_clk);
    #1;
    check("por", 32'(o_por_active), 32'h1);
    check("cfg_rst", 32'(o_cfg), 32'h00);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    n = 0;
    while (o_converting !== 1'b1 && n < 1000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("por_len", 32'(n), 32'(P_POR));
    conv_check(TMXA, TMXA, 1'b1);
    check("addr_lsb", 32'(o_addr_lsb), 32'(pin_static));
    for (int m = 0; m < 8; m++) begin
      access({own_upper, pin_static}, 1'b0, 1'b1, {2'h0, 3'($random(seed)), 3'(m)}, 1'b1);
    end
    access(acs_pkg::GLOBAL_ADDR, 1'b0, 1'b0, 8'h00, 1'b1);
    access(acs_pkg::GLOBAL_ADDR, 1'b0, 1'b1, 8'h06, 1'b1);
    access({own_upper, pin_static}, 1'b0, 1'b0, 8'h00, 1'b1);
    access(acs_pkg::GLOBAL_ADDR, 1'b1, 1'b0, 8'h00, 1'b0);
    access({own_upper, pin_static} ^ 7'h02, 1'b0, 1'b1, 8'h01, 1'b0);
    access({own_upper, pin_static}, 1'b1, 1'b0, 8'h00, 1'b1);
    ext_en <= 1'b1;
    repeat (200) @(posedge i_sys_clk);
    #1;
    check("ext_on", 32'(o_ext_clk_present), 32'h1);
    check("addr_lsb_ext", 32'(o_addr_lsb), 32'h1);
    ext_on = 1'b1;
    access({own_upper, 1'b1}, 1'b0, 1'b1, 8'h02, 1'b1);
    access({own_upper, 1'b1}, 1'b0, 1'b1, 8'h06, 1'b1);
    ext_per <= 400;
    repeat (900) @(posedge i_sys_clk);
    u_host.xfer({own_upper, 1'b1}, 1'b0, 1'b1, 8'h01, 1'b0, ack);
    check("ack_ext", 32'(ack), 32'h1);
    exp_cfg = 8'h01;
    repeat (500) @(posedge i_sys_clk);
    ext_en <= 1'b0;
    n = 0;
    while (o_converting !== 1'b0 && n < 10000) begin
      @(posedge i_sys_clk);
      n++;
    end
    repeat (2600) @(posedge i_sys_clk);
    #1;
    check("suspect", 32'(o_result_suspect), 32'h1);
    check("ext_lost", 32'(o_ext_clk_present), 32'h0);
    check("addr_lsb_pin", 32'(o_addr_lsb), 32'(pin_static));
    ext_on = 1'b0;
    access({own_upper, pin_static}, 1'b0, 1'b0, 8'h00, 1'b1);
    check("clean", 32'(o_result_suspect), 32'h0);
    ext_per <= 3200;
    ext_en <= 1'b1;
    repeat (4) begin
      repeat (2000) @(posedge i_sys_clk);
      #1;
      check("slow_clk", 32'(o_ext_clk_present), 32'h0);
    end
    finish_test();
  end
endmodule : acs_sequencer_tb
